// ### core/epo_current_conditioner.sv
`timescale 1ns/1ns
`include "epo_regs.svh"

module epo_current_conditioner
  import epo_pkg::*;
#(
  parameter int W         = 16,
  parameter int HP_SHIFT  = 10,
  parameter int LAG_SHIFT = 12
) (
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic                in_valid,
  input  wire logic signed [W-1:0] in_current,
  output logic                     out_valid,
  output logic signed [W-1:0]      out_current
);

  localparam int EW = W + HP_SHIFT + 2;

  logic signed [EW-1:0] x_prev_ff;
  logic signed [EW-1:0] hp_ff;
  logic signed [EW-1:0] lag_ff;
  logic                 hp_valid_ff;
  logic                 lag_valid_ff;
  logic signed [EW-1:0] x_ext;
  logic signed [EW-1:0] nxt_hp;
  logic signed [EW-1:0] nxt_lag;

  ////////////////////////////////////////////////////////////////////////////////
  // The input is scaled up so the slow pole keeps its fraction bits.
  assign x_ext   = EW'(in_current) <<< HP_SHIFT;
  // One-pole high-pass: the dc term cancels, so an offset never reaches the multiplier.
  assign nxt_hp  = x_ext - x_prev_ff + hp_ff - (hp_ff >>> HP_SHIFT);
  // A slight lag, mostly the new sample with a trace of the last, cancels the high-pass lead.
  // A heavy pole here would smear the current and spoil the power product.
  assign nxt_lag = hp_ff - ((hp_ff - lag_ff) >>> LAG_SHIFT);

  // Filter states update only on a new sample.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      x_prev_ff <= '0;
      hp_ff     <= '0;
      lag_ff    <= '0;
    end else begin
      if (in_valid) begin
        x_prev_ff <= x_ext;
        hp_ff     <= nxt_hp;
      end
      if (hp_valid_ff) begin
        lag_ff <= nxt_lag;
      end
    end
  end

  // Valid follows the data through both stages.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hp_valid_ff  <= 1'b0;
      lag_valid_ff <= 1'b0;
    end else begin
      hp_valid_ff  <= in_valid;
      lag_valid_ff <= hp_valid_ff;
    end
  end

  assign out_valid   = lag_valid_ff;
  assign out_current = W'(lag_ff >>> HP_SHIFT);

endmodule

// ### core/epo_pkg.sv
package epo_pkg;

  // Sample pair from the two converters, one strobe for both.
  typedef struct packed {
    logic               valid;
    logic signed [15:0] voltage;
    logic signed [15:0] current;
  } epo_sample_type;

  // Externally strapped selection pins.
  typedef struct packed {
    logic base_freq_select_hi;
    logic base_freq_select_lo;
    logic calibration_rate_select;
    logic cal_high_freq_mode;
  } epo_sel_type;

  // Which low-frequency output takes the next half-period event.
  typedef enum logic {
    EPO_NEXT_A = 1'b0,
    EPO_NEXT_B = 1'b1
  } epo_phase_type;

endpackage

// ### core/epo_pulse_outputs.sv
`timescale 1ns/1ns
`include "epo_regs.svh"
// Notes on behaviour
// - Low-frequency outputs pulse low for 550 ms when the period allows it.
// - Second low-frequency output falls half a period after the first.
// - Calibration output pulses high for 180 ms at normal rates.
// - High-frequency calibration mode makes every calibration pulse 18 us high unless a new calibration event restarts it first.
// - At fast rates both low-frequency widths shrink to fit the period, and so does the calibration width outside high-frequency mode.
// - Output periods follow the selected power-to-frequency thresholds.
// - Current channel is high-pass filtered so dc offset never enters power.
// - A lag stage in the current channel cancels the high-pass phase lead.
// - Two select inputs pick one of four base frequencies.
// - A calibration select input picks the calibration frequency scaling.

module epo_pulse_outputs
  import epo_pkg::*;
#(
  parameter int          CNT_W       = 32,
  parameter int          ACC_W       = 48,
  parameter int          LF_WIDTH    = `EPO_LF_WIDTH_MS * (`EPO_CLK_HZ / 1000),
  parameter int          CF_WIDTH    = `EPO_CF_WIDTH_MS * (`EPO_CLK_HZ / 1000),
  parameter logic [47:0] LF_THR0     = 48'h0000_4000_0000,
  parameter logic [47:0] LF_THR1     = 48'h0000_2000_0000,
  parameter logic [47:0] LF_THR2     = 48'h0000_1000_0000,
  parameter logic [47:0] LF_THR3     = 48'h0000_0800_0000
) (
  input  wire logic           sys_clk,
  input  wire logic           rstn,
  input  wire epo_sample_type sample,
  input  wire epo_sel_type    sel,
  output logic                low_freq_out_a,
  output logic                low_freq_out_b,
  output logic                calibration_out
);

  localparam int CF_HF_WIDTH =
    (`EPO_CF_HF_WIDTH_US * (`EPO_CLK_HZ / 1000) + 999) / 1000;

  logic signed [15:0]      cur_hp;
  logic                    cur_valid;
  logic signed [15:0]      volt_dly_ff [`EPO_COND_LATENCY];
  logic signed [31:0]      power_ff;
  logic                    power_valid_ff;
  logic signed [ACC_W-1:0] lf_acc_ff;
  logic signed [ACC_W-1:0] cf_acc_ff;
  logic [ACC_W-1:0]        lf_thr;
  logic [ACC_W-1:0]        cf_thr;
  logic                    lf_event;
  logic                    cf_event;
  epo_phase_type           next_ff;
  logic [CNT_W-1:0]        lf_gap_ff;
  logic [CNT_W-1:0]        cf_gap_ff;
  logic [CNT_W-1:0]        a_cnt_ff;
  logic [CNT_W-1:0]        b_cnt_ff;
  logic [CNT_W-1:0]        cf_cnt_ff;
  logic [CNT_W-1:0]        lf_load;
  logic [CNT_W-1:0]        cf_load;
  logic                    low_freq_out_a_ff;
  logic                    low_freq_out_b_ff;
  logic                    calibration_out_ff;

  // Nominal width, or what the measured spacing leaves room for, never below one cycle.
  function automatic logic [CNT_W-1:0] fit_width(input logic [CNT_W-1:0] nominal,
                                                 input logic [CNT_W-1:0] room);
    logic [CNT_W-1:0] w;
    w = (room < nominal) ? room : nominal;
    return (w == '0) ? CNT_W'(1) : w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Current conditioning: offset removal and phase match.
  epo_current_conditioner #(
    .W         (16)
  ) u_cond (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .in_valid    (sample.valid),
    .in_current  (sample.current),
    .out_valid   (cur_valid),
    .out_current (cur_hp)
  );

  // The voltage is delayed to line up with the conditioned current.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int k = 0; k < `EPO_COND_LATENCY; k++) begin
        volt_dly_ff[k] <= '0;
      end
    end else begin
      volt_dly_ff[0] <= sample.voltage;
      for (int k = 1; k < `EPO_COND_LATENCY; k++) begin
        volt_dly_ff[k] <= volt_dly_ff[k-1];
      end
    end
  end

  // Instantaneous power, registered so the multiplier has a full cycle.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      power_ff       <= '0;
      power_valid_ff <= 1'b0;
    end else begin
      power_ff       <= cur_hp * volt_dly_ff[`EPO_COND_LATENCY-1];
      power_valid_ff <= cur_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Thresholds: the low-frequency one fires twice per output period, once per output.
  always_comb begin
    unique case ({sel.base_freq_select_hi, sel.base_freq_select_lo})
      2'b00: lf_thr = ACC_W'(LF_THR0);
      2'b01: lf_thr = ACC_W'(LF_THR1);
      2'b10: lf_thr = ACC_W'(LF_THR2);
      2'b11: lf_thr = ACC_W'(LF_THR3);
    endcase
    if (sel.cal_high_freq_mode) begin
      cf_thr = lf_thr >> `EPO_CF_SHIFT_HF;
    end else if (sel.calibration_rate_select) begin
      cf_thr = lf_thr >> `EPO_CF_SHIFT_HI;
    end else begin
      cf_thr = lf_thr >> `EPO_CF_SHIFT_LO;
    end
  end

  assign lf_event = (lf_acc_ff >= $signed({1'b0, lf_thr[ACC_W-1:1]}));
  assign cf_event = (cf_acc_ff >= $signed(cf_thr));

  // Energy integrators; each firing subtracts one quantum so no energy is lost.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lf_acc_ff <= '0;
      cf_acc_ff <= '0;
    end else begin
      lf_acc_ff <= lf_acc_ff
                   + (power_valid_ff ? ACC_W'(power_ff) : '0)
                   - (lf_event ? $signed({1'b0, lf_thr[ACC_W-1:1]}) : '0);
      cf_acc_ff <= cf_acc_ff
                   + (power_valid_ff ? ACC_W'(power_ff) : '0)
                   - (cf_event ? $signed(cf_thr) : '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Spacing since the last event, saturating so a slow rate reads as plenty of room.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lf_gap_ff <= '1;
      cf_gap_ff <= '1;
    end else begin
      lf_gap_ff <= lf_event ? CNT_W'(1) : ((lf_gap_ff == '1) ? lf_gap_ff : lf_gap_ff + 1'b1);
      cf_gap_ff <= cf_event ? CNT_W'(1) : ((cf_gap_ff == '1) ? cf_gap_ff : cf_gap_ff + 1'b1);
    end
  end

  // The half-period gap bounds each output's width so it recovers no later than the cycle its partner falls.
  assign lf_load = fit_width(CNT_W'(LF_WIDTH), lf_gap_ff);
  // In high-frequency mode the width is fixed; otherwise it fits half the period.
  assign cf_load = sel.cal_high_freq_mode ? CNT_W'(CF_HF_WIDTH)
                 : fit_width(CNT_W'(CF_WIDTH), cf_gap_ff >> 1);

  // Half-period events alternate between the two outputs.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      next_ff <= EPO_NEXT_A;
    end else if (lf_event) begin
      next_ff <= (next_ff == EPO_NEXT_A) ? EPO_NEXT_B : EPO_NEXT_A;
    end
  end

  // Width counters: a new event restarts the pulse it belongs to.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      a_cnt_ff  <= '0;
      b_cnt_ff  <= '0;
      cf_cnt_ff <= '0;
    end else begin
      if (lf_event && next_ff == EPO_NEXT_A) begin
        a_cnt_ff <= lf_load;
      end else if (lf_event) begin
        // The partner's fall ends this pulse, so the next own event always shows a fall.
        a_cnt_ff <= '0;
      end else if (a_cnt_ff != '0) begin
        a_cnt_ff <= a_cnt_ff - 1'b1;
      end
      if (lf_event && next_ff == EPO_NEXT_B) begin
        b_cnt_ff <= lf_load;
      end else if (lf_event) begin
        b_cnt_ff <= '0;
      end else if (b_cnt_ff != '0) begin
        b_cnt_ff <= b_cnt_ff - 1'b1;
      end
      if (cf_event) begin
        cf_cnt_ff <= cf_load;
      end else if (cf_cnt_ff != '0) begin
        cf_cnt_ff <= cf_cnt_ff - 1'b1;
      end
    end
  end

  // Pins are registered; a pulse is active while its counter is loaded.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      low_freq_out_a_ff  <= 1'b1;
      low_freq_out_b_ff  <= 1'b1;
      calibration_out_ff <= 1'b0;
    end else begin
      low_freq_out_a_ff  <= (a_cnt_ff == '0);
      low_freq_out_b_ff  <= (b_cnt_ff == '0);
      calibration_out_ff <= (cf_cnt_ff != '0);
    end
  end

  assign low_freq_out_a  = low_freq_out_a_ff;
  assign low_freq_out_b  = low_freq_out_b_ff;
  assign calibration_out = calibration_out_ff;

endmodule

// ### core/epo_regs.svh
`ifndef EPO_REGS_SVH
`define EPO_REGS_SVH

// System clock rate in hertz.
`define EPO_CLK_HZ          100000000
// Nominal pulse widths, in their own units.
`define EPO_LF_WIDTH_MS     550
`define EPO_CF_WIDTH_MS     180
`define EPO_CF_HF_WIDTH_US  18
// Calibration threshold divider, as a right shift of the low-frequency threshold.
`define EPO_CF_SHIFT_LO     4
`define EPO_CF_SHIFT_HI     6
`define EPO_CF_SHIFT_HF     10
// Pipeline latency of the current conditioner, in cycles.
`define EPO_COND_LATENCY    2

`endif

// ### tb/epo_pulse_checker.sv
`timescale 1ns/1ns
`include "epo_regs.svh"
module epo_pulse_checker
  import epo_pkg::*;
#(
  parameter int LF_WIDTH = 200,
  parameter int CF_WIDTH = 60
) (
  input wire logic           sys_clk,
  input wire logic           rstn,
  input wire epo_sample_type sample,
  input wire epo_sel_type    sel,
  input wire logic           low_freq_out_a,
  input wire logic           low_freq_out_b,
  input wire logic           calibration_out
);
  localparam int HF_W = `EPO_CF_HF_WIDTH_US * (`EPO_CLK_HZ / 1000000);
  int   a_ff = 0;
  int   b_ff = 0;
  int   c_ff = 0;
  logic turn_b_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Active run lengths; a restarted pulse keeps counting, so restarts cannot hide.
  always_ff @(posedge sys_clk) begin
    a_ff <= low_freq_out_a ? 0 : a_ff + 1;
    b_ff <= low_freq_out_b ? 0 : b_ff + 1;
    c_ff <= calibration_out ? c_ff + 1 : 0;
  end
  // Whose falling edge is due next.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      turn_b_ff <= 1'h0;
    end else if ($fell(low_freq_out_a) || $fell(low_freq_out_b)) begin
      turn_b_ff <= !turn_b_ff;
    end
  end
  sequence s_idle;
    (!sample.valid) [*8];
  endsequence
  property p_rest;
    $rose(rstn) |-> low_freq_out_a && low_freq_out_b && !calibration_out;
  endproperty
  property p_a_w; a_ff <= LF_WIDTH; endproperty
  property p_b_w; b_ff <= LF_WIDTH; endproperty
  property p_cf_w; c_ff <= (sel.cal_high_freq_mode ? HF_W : CF_WIDTH); endproperty
  property p_cf_hf; $fell(calibration_out) && sel.cal_high_freq_mode |-> c_ff == HF_W; endproperty
  property p_a_turn; $fell(low_freq_out_a) |-> !turn_b_ff; endproperty
  property p_b_turn; $fell(low_freq_out_b) |-> turn_b_ff; endproperty
  property p_idle;
    s_idle |=> !$fell(low_freq_out_a) && !$fell(low_freq_out_b) && !$rose(calibration_out);
  endproperty
  a_rest: assert property (p_rest) else $error("not at rest");
  a_a_w: assert property (p_a_w) else $error("a too long");
  a_b_w: assert property (p_b_w) else $error("b too long");
  a_cf_w: assert property (p_cf_w) else $error("cal too long");
  a_cf_hf: assert property (p_cf_hf) else $error("cal hf width");
  a_a_turn: assert property (p_a_turn) else $error("a out of turn");
  a_b_turn: assert property (p_b_turn) else $error("b out of turn");
  a_idle: assert property (p_idle) else $error("pulse with no power");
endmodule
bind epo_pulse_outputs epo_pulse_checker #(.LF_WIDTH(LF_WIDTH), .CF_WIDTH(CF_WIDTH)) u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .sample(sample), .sel(sel),
  .low_freq_out_a(low_freq_out_a), .low_freq_out_b(low_freq_out_b),
  .calibration_out(calibration_out));

// ### tb/epo_pulse_meter.sv
`timescale 1ns/1ns
// Far-side input stage: times each pulse in cycles and reports it on return to rest.
module epo_pulse_meter (
  input  wire logic sys_clk,
  input  wire logic low_a,
  input  wire logic low_b,
  input  wire logic cal,
  output logic      lf_done,
  output logic      lf_ch,
  output int        lf_w,
  output logic      cf_done,
  output int        cf_w
);
  int a_ff = 0;
  int b_ff = 0;
  int c_ff = 0;
  // A report fires one cycle after the line is back at rest.
  always_ff @(posedge sys_clk) begin
    a_ff <= low_a ? 0 : a_ff + 1;
    b_ff <= low_b ? 0 : b_ff + 1;
    c_ff <= cal ? c_ff + 1 : 0;
    lf_done <= (low_a && a_ff > 0) || (low_b && b_ff > 0);
    lf_ch <= low_b && b_ff > 0;
    lf_w <= (low_b && b_ff > 0) ? b_ff : a_ff;
    cf_done <= !cal && c_ff > 0;
    cf_w <= c_ff;
  end
endmodule

// ### tb/tb_energy_pulse_outputs.sv
`timescale 1ns/1ns
module tb_energy_pulse_outputs
  import epo_pkg::*;
;
  typedef struct {logic ch; int lo; int hi;} epo_note_type;
  logic           sys_clk = 1'h0;
  logic           rstn = 1'h0;
  epo_sample_type sample = '0;
  epo_sel_type    sel = '0;
  logic           out_a, out_b, out_c, lf_done, lf_ch, cf_done;
  int             lf_w, cf_w, lf0, cf0, last_lf, cf_cnt[2];
  int             num_errors = 0;
  int             num_checks = 0;
  int             lf_seen = 0;
  int             cf_seen = 0;
  logic [15:0]    lfsr = 16'h3183;
  epo_note_type   lf_q[$];
  epo_note_type   cf_q[$];
  ////////////////////////////////////////////////////////////////
  always #5 sys_clk = ~sys_clk;
  // Default thresholds keep the four rates in rising order; test amplitudes are scaled to them.
  epo_pulse_outputs #(.LF_WIDTH(200), .CF_WIDTH(60)
  ) u_dut (.sys_clk(sys_clk), .rstn(rstn), .sample(sample), .sel(sel),
    .low_freq_out_a(out_a), .low_freq_out_b(out_b), .calibration_out(out_c));
  epo_pulse_meter u_meter (.sys_clk(sys_clk), .low_a(out_a), .low_b(out_b), .cal(out_c),
    .lf_done(lf_done), .lf_ch(lf_ch), .lf_w(lf_w), .cf_done(cf_done), .cf_w(cf_w));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic check_w(input string what, input int seen, input int lo, input int hi);
    num_checks++;
    if (seen < lo || seen > hi) begin
      num_errors++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Random valid spacing and sign; current shares the sign so power stays positive.
  task automatic run_power(input int amp, input int cycles);
    repeat (cycles) begin
      @(negedge sys_clk);
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      sample.valid = lfsr[0] && amp > 0;
      sample.voltage = lfsr[1] ? 16'(amp + lfsr[5:2]) : 16'(-amp - lfsr[5:2]);
      sample.current = sample.voltage;
    end
  endtask
  task automatic do_reset(input epo_sel_type s);
    @(negedge sys_clk);
    rstn = 1'h0;
    sel = s;
    repeat (5) @(negedge sys_clk);
    rstn = 1'h1;
    check("rest", {out_a, out_b, out_c}, 3'h6);
  endtask
  // Long idle tail lets a full calibration pulse finish before the next reset.
  task automatic drain(input string name, input int amp, input int limit);
    for (int n = 0; lf_q.size() + cf_q.size() > 0 && n < limit; n += 100) run_power(amp, 100);
    check("notes_left", lf_q.size() + cf_q.size(), 0);
    lf_q.delete();
    cf_q.delete();
    run_power(0, 2000);
    $display("test %s done", name);
  endtask
  // Each reported pulse is held against the oldest note still waiting.
  always @(negedge sys_clk) begin
    if (lf_done === 1'h1) begin
      lf_seen++;
      if (lf_q.size() > 0) begin
        check("lf_channel", lf_ch, lf_q[0].ch);
        check_w("lf_width", lf_w, lf_q[0].lo, lf_q[0].hi);
        void'(lf_q.pop_front());
      end
    end
    if (cf_done === 1'h1) begin
      cf_seen++;
      if (cf_q.size() > 0) begin
        check_w("cf_width", cf_w, cf_q[0].lo, cf_q[0].hi);
        void'(cf_q.pop_front());
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    do_reset(4'h8);
    lf_q = '{'{1'h0, 200, 200}, '{1'h1, 200, 200}, '{1'h0, 200, 200}};
    cf_q = '{'{1'h0, 60, 60}, '{1'h0, 60, 60}, '{1'h0, 60, 60}};
    drain("slow", 360, 10000);
    do_reset(4'hc);
    lf_q = '{'{1'h0, 1, 200}, '{1'h1, 1, 199}, '{1'h0, 1, 199}};
    cf_q = '{'{1'h0, 1, 60}, '{1'h0, 1, 59}, '{1'h0, 1, 59}};
    drain("fast", 2048, 2000);
    do_reset(4'h9);
    cf_q = '{'{1'h0, 1800, 1800}, '{1'h0, 1800, 1800}};
    drain("high_freq_cal", 4, 12000);
    for (int r = 0; r < 2; r++) begin
      for (int n = 0; n < 4; n++) begin
        do_reset(epo_sel_type'({n[1:0], r[0], 1'h0}));
        lf0 = lf_seen;
        cf0 = cf_seen;
        run_power(1000, 4096);
        run_power(0, 300);
        if (n > 0) check("lf_rate_up", lf_seen - lf0 > last_lf, 1'h1);
        last_lf = lf_seen - lf0;
        if (n == 0) cf_cnt[r] = cf_seen - cf0;
      end
    end
    check("cf_rate_up", cf_cnt[1] > cf_cnt[0], 1'h1);
    $display("test select_sweep done");
    finish_test();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    finish_test();
  end
endmodule
